// [cc_port_cfg.svh]
// Purpose: offsets, field positions and reset values of the line control bank
// Assumes: 32-bit APB, byte addresses, one word per register
// Notes: included by the bank module only
`ifndef CC_PORT_CFG_SVH
`define CC_PORT_CFG_SVH

`define ADDR_W 8
`define OFS_STATUS 8'h08
`define OFS_PORT 8'h0C
`define OFS_REF_ENABLE 8'h14

`define CNT_W 9
`define CNT_RSV_W 7
`define CNT_LSB 16
`define CNT_MSB 31
`define STATUS_LOW_W 16

`define LINE1_LSB 0
`define LINE2_LSB 16
`define LINE3_LSB 24
`define PORT_RSV_W 8
`define BYTE_W 8

`define CE_BIT 7
`define SEL_MSB 6
`define SEL_LSB 5
`define LVE_BIT 4
`define PU_MSB 3
`define PU_LSB 2
`define PD_BIT 1
`define RES_BIT 0

`define CTRL_RESET 7'h01
`define RESULT_RESET 1'h1
`define REF1_BIT 0
`define REF2_BIT 1
`define REF_RESET 2'h0
`define REF_RSV_W 30
`define ZERO_WORD 32'h0000_0000

`endif

// [cc_port_pkg.sv]
// Purpose: types shared by the line control bank
// Assumes: nothing beyond the configuration header
// Notes: field order of line_ctrl_t matches the control byte bits 7..1
package cc_port_pkg;

    typedef enum logic [1:0] {
        REF_0V55 = 2'h0,
        REF_0V22 = 2'h1,
        REF_0V66 = 2'h2,
        REF_1V23 = 2'h3
    } ref_level_t;

    typedef enum logic [1:0] {
        PULLUP_OFF = 2'h0,
        PULLUP_330UA = 2'h1,
        PULLUP_180UA = 2'h2,
        PULLUP_80UA = 2'h3
    } pullup_t;

    typedef struct packed {
        logic comparator_enable;
        ref_level_t reference_select;
        logic low_drive_enable;
        pullup_t pullup_current;
        logic sink_resistor_enable;
    } line_ctrl_t;

endpackage

// [cc_port_control_bank.sv]
// Purpose: APB register bank for the three configuration-channel line controls
// Assumes: analog front end inputs are synchronous to pclk
// Notes: zero-wait slave, prdata and pslverr are loaded in the setup cycle
// Summary of operation
// - read-only 9-bit byte count, bits 15:9 zero, resets to zero
// - byte count appears in bits 31:16 of the status word at 0x08
// - port word at 0x0C holds line one, two, three bytes; 15:8 reserved
// - comparator enable low keeps comparator off and forces result to one
// - reference selector bits 6:5 pick 0.55, 0.22, 0.66 or 1.23 volts
// - drive-level bit 4 selects normal or reduced low-voltage output drive
// - pull-up field bits 3:2 selects off, 330, 180 or 80 microamps
// - sink resistor bit 1 connects the 5.1 kilohm pull-down, resets to one
// - result bit 0 reads line level against reference, resets to one
// - line two byte mirrors line one layout on its own line
// - line three comparator behaves as line one, result one when disabled
`timescale 1ns/10ps
`include "cc_port_cfg.svh"

module cc_port_control_bank
    import cc_port_pkg::*;
#(
    parameter int LINES = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`CNT_W-1:0] phy_byte_count,
    input wire logic [`STATUS_LOW_W-1:0] phy_status_low,
    input wire logic line1_comparator_raw,
    input wire logic line2_comparator_raw,
    input wire logic line3_comparator_raw,
    output logic line1_comparator_enable,
    output ref_level_t line1_reference_select,
    output logic line1_low_drive_enable,
    output pullup_t line1_pullup_current,
    output logic line1_sink_resistor_enable,
    output logic line2_comparator_enable,
    output ref_level_t line2_reference_select,
    output logic line2_low_drive_enable,
    output pullup_t line2_pullup_current,
    output logic line2_sink_resistor_enable,
    output logic line3_comparator_enable,
    output ref_level_t line3_reference_select,
    output logic line3_low_drive_enable,
    output pullup_t line3_pullup_current,
    output logic line3_sink_resistor_enable
);

////////////////////////////////////////////////////////////////////////////////
// bus decode

    logic setup_phase;
    logic access_write;
    logic hit_status;
    logic hit_port;
    logic hit_ref;
    logic hit_any;

    assign setup_phase = psel && !penable;
    assign access_write = psel && penable && pwrite;
    assign hit_status = (paddr == `OFS_STATUS);
    assign hit_port = (paddr == `OFS_PORT);
    assign hit_ref = (paddr == `OFS_REF_ENABLE);
    assign hit_any = hit_status || hit_port || hit_ref;
    // no wait states: every register answers in the access cycle
    assign pready = 1'b1;

////////////////////////////////////////////////////////////////////////////////
// byte counter and reference enables

    logic [`CNT_W-1:0] byte_count;
    logic [1:0] reference_enable;
    logic line1_reference_enable;
    logic line2_reference_enable;

    // sampled every cycle so the read word is never torn mid-access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_count <= '0;
        end else begin
            byte_count <= phy_byte_count;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_enable <= `REF_RESET;
        end else if (access_write && hit_ref) begin
            reference_enable <= {pwdata[`REF2_BIT], pwdata[`REF1_BIT]};
        end
    end

    assign line1_reference_enable = reference_enable[`REF1_BIT];
    assign line2_reference_enable = reference_enable[`REF2_BIT];

////////////////////////////////////////////////////////////////////////////////
// per-line control bytes

    line_ctrl_t ctrl [LINES];
    logic [LINES-1:0] result;
    logic [LINES-1:0] raw;
    logic [LINES-1:0] pullup_gate;
    pullup_t pullup_out [LINES];
    logic [LINES*`BYTE_W-1:0] line_byte;

    assign raw = {line3_comparator_raw, line2_comparator_raw, line1_comparator_raw};
    // line three has no reference enable of its own and borrows line two's
    assign pullup_gate = {line2_reference_enable, line2_reference_enable,
        line1_reference_enable};

    genvar g;
    generate
        for (g = 0; g < LINES; g++) begin : gen_line
            localparam int LSB = (g == 0) ? `LINE1_LSB :
                (g == 1) ? `LINE2_LSB : `LINE3_LSB;

            // result bit in pwdata is dropped: read-only
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl[g] <= line_ctrl_t'(`CTRL_RESET);
                end else if (access_write && hit_port) begin
                    ctrl[g] <= line_ctrl_t'(pwdata[LSB+`CE_BIT:LSB+`PD_BIT]);
                end
            end

            // a disabled comparator reads as above reference
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    result[g] <= `RESULT_RESET;
                end else if (!ctrl[g].comparator_enable) begin
                    result[g] <= 1'b1;
                end else begin
                    result[g] <= raw[g];
                end
            end

            // pull-up only reaches the pad with its reference switched on
            assign pullup_out[g] = pullup_gate[g] ? ctrl[g].pullup_current
                : PULLUP_OFF;
            assign line_byte[g*`BYTE_W +: `BYTE_W] = {ctrl[g], result[g]};
        end
    endgenerate

////////////////////////////////////////////////////////////////////////////////
// analog front end controls

    assign line1_comparator_enable = ctrl[0].comparator_enable;
    assign line1_reference_select = ctrl[0].reference_select;
    assign line1_low_drive_enable = ctrl[0].low_drive_enable;
    assign line1_pullup_current = pullup_out[0];
    assign line1_sink_resistor_enable = ctrl[0].sink_resistor_enable;
    assign line2_comparator_enable = ctrl[1].comparator_enable;
    assign line2_reference_select = ctrl[1].reference_select;
    assign line2_low_drive_enable = ctrl[1].low_drive_enable;
    assign line2_pullup_current = pullup_out[1];
    assign line2_sink_resistor_enable = ctrl[1].sink_resistor_enable;
    assign line3_comparator_enable = ctrl[2].comparator_enable;
    assign line3_reference_select = ctrl[2].reference_select;
    assign line3_low_drive_enable = ctrl[2].low_drive_enable;
    assign line3_pullup_current = pullup_out[2];
    assign line3_sink_resistor_enable = ctrl[2].sink_resistor_enable;

////////////////////////////////////////////////////////////////////////////////
// read data

    logic [31:0] next_prdata;

    always_comb begin
        next_prdata = `ZERO_WORD;
        if (hit_status) begin
            next_prdata = {{`CNT_RSV_W{1'b0}}, byte_count, phy_status_low};
        end else if (hit_port) begin
            next_prdata = {line_byte[2*`BYTE_W +: `BYTE_W], line_byte[`BYTE_W +: `BYTE_W],
                {`PORT_RSV_W{1'b0}}, line_byte[0 +: `BYTE_W]};
        end else if (hit_ref) begin
            next_prdata = {{`REF_RSV_W{1'b0}}, reference_enable};
        end
    end

    // loaded in setup so the access cycle already shows the answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `ZERO_WORD;
        end else if (setup_phase && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup_phase) begin
            pslverr <= !hit_any;
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence read_setup(logic [`ADDR_W-1:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence

    sequence write_access(logic [`ADDR_W-1:0] a);
        psel && penable && pwrite && paddr == a;
    endsequence

    sequence write_setup(logic [`ADDR_W-1:0] a);
        psel && !penable && pwrite && paddr == a;
    endsequence

    count_read_a: assert property (
        read_setup(`OFS_STATUS) |=> prdata[`CNT_MSB:`CNT_LSB]
            == {{`CNT_RSV_W{1'b0}}, $past(byte_count)})
        else $error("status read lost byte count");

    count_follow_a: assert property (
        presetn |=> byte_count == $past(phy_byte_count))
        else $error("byte count not sampled");

    port_rsv_a: assert property (
        read_setup(`OFS_PORT) |=> prdata[15:8] == 8'h00
            && prdata[7:0] == {$past(ctrl[0]), $past(result[0])})
        else $error("port word layout wrong");

    port_write_a: assert property (
        write_access(`OFS_PORT) |=> ctrl[1] == line_ctrl_t'($past(pwdata[23:17]))
            && ctrl[2] == line_ctrl_t'($past(pwdata[31:25])))
        else $error("line two or three byte not stored");

    result_forced_a: assert property (
        !line3_comparator_enable |=> result[2] == 1'b1)
        else $error("disabled comparator result not one");

    result_follow_a: assert property (
        line1_comparator_enable && !line1_comparator_raw ##1
            line1_comparator_enable |-> result[0] == 1'b0)
        else $error("result does not track line level");

    pullup_gate_a: assert property (
        !line2_reference_enable |-> line3_pullup_current == PULLUP_OFF
            && line2_pullup_current == PULLUP_OFF)
        else $error("pull-up active without reference");

    sink_hold_a: assert property (
        !access_write |=> line1_sink_resistor_enable == $past(line1_sink_resistor_enable))
        else $error("sink resistor changed without write");

    unmapped_a: assert property (
        psel && !penable && !hit_any |=> pslverr && pready)
        else $error("unmapped access not flagged");

    ready_high_a: assert property (
        psel && penable |-> pready)
        else $error("access cycle without ready");

    line1_write_a: assert property (
        write_access(`OFS_PORT) |=> ctrl[0]
            == line_ctrl_t'($past(pwdata[`LINE1_LSB+`CE_BIT:`LINE1_LSB+`PD_BIT])))
        else $error("line one byte not stored");

    write_pair_a: assert property (
        write_setup(`OFS_PORT) ##1 write_access(`OFS_PORT) |=>
            line2_comparator_enable == $past(pwdata[`LINE2_LSB+`CE_BIT])
            && line2_sink_resistor_enable == $past(pwdata[`LINE2_LSB+`PD_BIT]))
        else $error("line two controls not taken from write");

    ref_write_a: assert property (
        write_access(`OFS_REF_ENABLE) |=> line2_reference_enable == $past(pwdata[`REF2_BIT])
            && line1_reference_enable == $past(pwdata[`REF1_BIT]))
        else $error("reference enables not stored");

    ctrl_hold_a: assert property (
        !(access_write && hit_port) |=> $stable(ctrl[0]) && $stable(ctrl[1])
            && $stable(ctrl[2]))
        else $error("control byte changed without port write");

    ref_hold_a: assert property (
        !(access_write && hit_ref) |=> $stable(reference_enable))
        else $error("reference enable changed without write");

    status_low_a: assert property (
        read_setup(`OFS_STATUS) |=> prdata[`STATUS_LOW_W-1:0] == $past(phy_status_low))
        else $error("status low half not passed through");

    upper_read_a: assert property (
        read_setup(`OFS_PORT) |=>
            prdata[`LINE3_LSB +: `BYTE_W] == {$past(ctrl[2]), $past(result[2])}
            && prdata[`LINE2_LSB +: `BYTE_W] == {$past(ctrl[1]), $past(result[1])})
        else $error("line two or three byte read wrong");

    ref_read_a: assert property (
        read_setup(`OFS_REF_ENABLE) |=>
            prdata == {{`REF_RSV_W{1'b0}}, $past(reference_enable)})
        else $error("reference enable read wrong");

    unmapped_zero_a: assert property (
        setup_phase && !pwrite && !hit_any |=> prdata == `ZERO_WORD)
        else $error("unmapped read not zero");

    mapped_ok_a: assert property (
        setup_phase && hit_any |=> !pslverr)
        else $error("mapped access flagged as error");

    error_clear_a: assert property (
        !psel |=> !pslverr)
        else $error("error flag left after transfer");

    pullup1_gate_a: assert property (
        !line1_reference_enable |-> line1_pullup_current == PULLUP_OFF)
        else $error("line one pull-up active without reference");

    pullup_pass_a: assert property (
        line2_reference_enable |-> line3_pullup_current == ctrl[2].pullup_current
            && line2_pullup_current == ctrl[1].pullup_current)
        else $error("enabled pull-up not passed to line");

    result_high_a: assert property (
        !line1_comparator_enable && !line2_comparator_enable |=> result[0] && result[1])
        else $error("disabled comparator result not one");

    result_track_a: assert property (
        line2_comparator_enable && line3_comparator_enable |=>
            result[1] == $past(line2_comparator_raw)
            && result[2] == $past(line3_comparator_raw))
        else $error("result does not follow comparator");

    drive_hold_a: assert property (
        !access_write |=> line1_low_drive_enable == $past(line1_low_drive_enable))
        else $error("drive level changed without write");

endmodule

// [cc_line_front_end.sv]
// Purpose: behavioural analog front end of one configuration-channel line
// Assumes: line level given in millivolts by the bench
// Notes: output is meaningless while the comparator is off, so it toggles
`timescale 1ns/10ps

module cc_line_front_end
    import cc_port_pkg::*;
(
    input wire logic pclk,
    input wire logic comparator_enable,
    input wire ref_level_t reference_select,
    input wire integer line_mv,
    output logic comparator_raw
);
    int ref_mv;
    logic junk;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        case (reference_select)
            REF_0V55: ref_mv = 550;
            REF_0V22: ref_mv = 220;
            REF_0V66: ref_mv = 660;
            default: ref_mv = 1230;
        endcase
    end

    // unpowered comparator gives no stable level; toggle so nothing relies on it
    always_ff @(posedge pclk) begin
        junk <= (junk !== 1'b1);
    end

    assign comparator_raw = comparator_enable ? (line_mv > ref_mv) : junk;
endmodule

// [tb_cc_port_control_bank.sv]
// Purpose: self-checking bench of the line control register bank
// Assumes: zero-wait APB slave, front end models on all three lines
// Notes: line levels fixed at 400, 700 and 1000 mV
`timescale 1ns/10ps

module tb_cc_port_control_bank
    import cc_port_pkg::*;
;
    typedef struct packed {
        logic [31:0] wr;
        logic [1:0] refen;
        logic [31:0] rd;
    } row_t;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [8:0] phy_byte_count;
    logic [15:0] phy_status_low;
    logic c1, c2, c3, raw1, raw2, raw3, lv1, lv2, lv3, pd1, pd2, pd3, e;
    ref_level_t s1, s2, s3;
    pullup_t p1, p2, p3;
    int fail_count = 0;
    int n_tests = 0;
    row_t rows [4] = '{
        '{32'h8F99_FF87, 2'h1, 32'h8F99_0086},
        '{32'hF5C2_AAA0, 2'h2, 32'hF4C3_00A1},
        '{32'h0E02_007C, 2'h3, 32'h0F03_007D},
        '{32'h3389_5A6B, 2'h2, 32'h3389_006B}};

    ////////////////////////////////////////////////////////////////////////
    cc_port_control_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phy_byte_count(phy_byte_count), .phy_status_low(phy_status_low),
        .line1_comparator_raw(raw1), .line2_comparator_raw(raw2),
        .line3_comparator_raw(raw3), .line1_comparator_enable(c1),
        .line1_reference_select(s1), .line1_low_drive_enable(lv1),
        .line1_pullup_current(p1), .line1_sink_resistor_enable(pd1),
        .line2_comparator_enable(c2), .line2_reference_select(s2),
        .line2_low_drive_enable(lv2), .line2_pullup_current(p2),
        .line2_sink_resistor_enable(pd2), .line3_comparator_enable(c3),
        .line3_reference_select(s3), .line3_low_drive_enable(lv3),
        .line3_pullup_current(p3), .line3_sink_resistor_enable(pd3));
    cc_line_front_end u_fe1 (.pclk(pclk), .comparator_enable(c1),
        .reference_select(s1), .line_mv(400), .comparator_raw(raw1));
    cc_line_front_end u_fe2 (.pclk(pclk), .comparator_enable(c2),
        .reference_select(s2), .line_mv(700), .comparator_raw(raw2));
    cc_line_front_end u_fe3 (.pclk(pclk), .comparator_enable(c3),
        .reference_select(s3), .line_mv(1000), .comparator_raw(raw3));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [6:0] expc(input logic [7:0] b, input logic g);
        expc = {b[7:2] & {4'hF, g, g}, b[1]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic reset_check();
        apb(0, 8'h0C, 0);
        chk(r, 32'h0303_0003);
        apb(0, 8'h14, 0);
        chk(r, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0000);
        chk({c3, s3, lv3, p3, pd3, c2, s2, lv2, p2, pd2, c1, s1, lv1, p1, pd1},
            32'h0000_4081);
        $display("reset values test done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        results();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        phy_byte_count = 9'h000;
        phy_status_low = 16'hBEEF;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        apb(0, 8'h08, 0);
        chk(r, 32'h0000_BEEF);
        reset_check();
        foreach (rows[i]) begin
            apb(1, 8'h14, 32'hFFFF_FFFC | rows[i].refen);
            apb(1, 8'h0C, rows[i].wr);
            repeat (3) @(posedge pclk);
            apb(0, 8'h0C, 0);
            chk(r, rows[i].rd);
            chk({31'h0, e}, 32'h0000_0000);
            apb(0, 8'h14, 0);
            chk(r, {30'h0, rows[i].refen});
            chk({c3, s3, lv3, p3, pd3, c2, s2, lv2, p2, pd2, c1, s1, lv1, p1, pd1},
                {expc(rows[i].wr[31:24], rows[i].refen[1]),
                expc(rows[i].wr[23:16], rows[i].refen[1]),
                expc(rows[i].wr[7:0], rows[i].refen[0])});
            $display("row %0d test done", i);
        end
        // status word keeps the count high, ignores writes and reserved bits
        phy_byte_count <= 9'h1A5;
        apb(1, 8'h08, 32'hFFFF_FFFF);
        apb(0, 8'h08, 0);
        chk(r, 32'h01A5_BEEF);
        apb(0, 8'h10, 0);
        chk(r, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        $display("status and unmapped test done");
        // reset in mid-run returns every line to its documented state
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        reset_check();
        results();
    end
endmodule
